// ---- src/smc_ctrl.sv ----
// standby mode controller: idle, software stop, clock output inhibit
// assumes an apb master on pclk, pins arriving asynchronously, pad logic
// that applies the enables below to the clock gates and bus pads
//
// Behaviour
// - idle keeps oscillator, gates system clock
// - idle exit resumes at once, no wait
// - idle halts cpu, peripherals; contents retained
// - standby with ext_expansion floats buses, strobes high; dram runs
// - standby ignores hold/wait, floats ack, sys_clock_out_pin low
// - idle exits only on nmi or reset
// - idle in nmi service: exit, keep pending
// - reset pin release equals system reset
// - stop halts oscillator, pll, all clocks
// - stop exits on nmi/reset, resonator waits
// - stop in nmi service: exit, keep pending
// - both disable bits stop sys_clock_out_pin pin
// - flash programming never drives sys_clock_out_pin
// - nmi edge releases, count on inactive edge
// - after count restart clock, take nmi
// - reset low releases stop, run after rise
// - resonator mode counts before execution resumes
// - count clock is fxx/2^8 or fxx/2^9
// - idle bit enters idle, with stop bit stop
// - idle bit self-clears on release
// - disable field bits 7:6, 11 inhibits
// - external clock cuts feedback, skips count
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module smc_ctrl #(
   parameter int TBC_DIV_LOG2 = smc_pkg::SMC_TBC_DIV_LOG2,
   parameter int TBC_TICKS = smc_pkg::SMC_TBC_TICKS,
   parameter bit NMI_VALID_FALLING = 1'b1 // valid nmi edge polarity
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_pin,
   input wire logic reset_pin_n,
   input wire logic direct_clock_strap,
   input wire logic flash_prog_mode,
   input wire logic ext_expansion,
   input wire logic nmi_in_service,
   output logic sys_clock_en,
   output logic osc_enable,
   output logic pll_enable,
   output logic osc_feedback_cut,
   output logic bus_drive_en,
   output logic strobes_force_high,
   output logic dram_refresh_run,
   output logic bus_hold_ack_oe,
   output logic hold_wait_sample_en,
   output logic sys_clock_out_pin_run,
   output logic sys_clock_out_pin_oe,
   output logic nmi_wake_ack,
   output logic nmi_wake_pend,
   output logic sys_reset_req
);
   import smc_pkg::*;

   typedef struct packed {
      smc_mode_t mode; // standby mode
      logic [7:0] power_save_ctrl_reg; // power_save_ctrl_reg contents
      logic [31:0] prdata; // read data caught in setup phase
      logic pslverr; // unmapped address flag caught in setup phase
      logic [2:0] nmi_sync; // two synchroniser stages and an edge history
      logic [1:0] rst_sync; // reset pin synchroniser
      logic [1:0] strap_sync; // strap synchroniser
      logic [1:0] flash_sync; // flash mode synchroniser
      logic [1:0] exp_sync; // expansion mode synchroniser
      logic ack; // nmi acknowledged with the exit
      logic pend; // nmi held pending
      logic tbc_start; // start pulse to the counter
      logic in_nmi; // standby was entered from nmi service
   } smc_state_t;

   smc_state_t cur;
   smc_state_t next_cur;

   logic nmi_lvl; // synchronised nmi level
   logic nmi_prev; // one cycle older level
   logic nmi_valid_edge; // valid edge seen
   logic nmi_inactive; // pin back at inactive level
   logic rst_active; // reset pin held low
   logic strap; // synchronised strap
   logic apb_setup; // setup phase of a transfer
   logic apb_wr; // write taking effect
   logic psc_hit; // control register addressed
   logic stat_hit; // status register addressed
   logic [31:0] stat_word; // status read value
   logic standby; // idle, stop or stop release in progress
   logic tbc_busy; // counter running
   logic tbc_done; // counter finished
   logic skip_count; // stop release needs no stabilisation count
   logic [7:0] wr_byte; // write data for the control register

   // stage 2 and stage 3 are the only readers of the synchronised pins
   assign nmi_lvl = cur.nmi_sync[1];
   assign nmi_prev = cur.nmi_sync[2];
   assign nmi_valid_edge = NMI_VALID_FALLING ? (nmi_prev && !nmi_lvl) : (!nmi_prev && nmi_lvl);
   assign nmi_inactive = NMI_VALID_FALLING ? nmi_lvl : !nmi_lvl;
   assign rst_active = !cur.rst_sync[1];
   assign strap = cur.strap_sync[1];

   // apb decode
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite && !cur.pslverr;
   assign psc_hit = paddr == SMC_PSC_OFFSET;
   assign stat_hit = paddr == SMC_STAT_OFFSET;
   assign wr_byte = pwdata[7:0];

   // external clock or direct mode never counts stabilisation
   assign skip_count = cur.power_save_ctrl_reg[SMC_OSC_SOURCE_SELECT_BIT] || strap;

   // standby covers every mode but run
   assign standby = cur.mode != SMC_RUN;

   // status word, unused bits read as zero
   always_comb
   begin
      stat_word = 32'h0000_0000;
      stat_word[SMC_ST_IDLE_BIT] = cur.mode == SMC_IDLE;
      stat_word[SMC_ST_STOP_BIT] = cur.mode == SMC_STOP;
      stat_word[SMC_ST_INACT_BIT] = cur.mode == SMC_WAIT_INACT;
      stat_word[SMC_ST_STAB_BIT] = tbc_busy;
      stat_word[SMC_ST_RST_BIT] = rst_active;
      stat_word[SMC_ST_STRAP_BIT] = strap;
   end

   // stabilisation counter
   smc_tbc #(
      .DIV_LOG2(TBC_DIV_LOG2),
      .TICKS(TBC_TICKS)
   ) u_tbc (
      .clk(pclk),
      .rst_n(presetn),
      .start(cur.tbc_start),
      .sel(cur.power_save_ctrl_reg[SMC_STAB_CLOCK_SELECT_BIT]),
      .busy(tbc_busy),
      .done(tbc_done)
   );

   // next state: synchronisers, bus slave, mode sequencing
   always_comb
   begin
      next_cur = cur;
      next_cur.ack = 1'b0;
      next_cur.pend = 1'b0;
      next_cur.tbc_start = 1'b0;

      // two-flop synchronisers, third nmi stage only for edge history
      next_cur.nmi_sync = {cur.nmi_sync[1:0], nmi_pin};
      next_cur.rst_sync = {cur.rst_sync[0], reset_pin_n};
      next_cur.strap_sync = {cur.strap_sync[0], direct_clock_strap};
      next_cur.flash_sync = {cur.flash_sync[0], flash_prog_mode};
      next_cur.exp_sync = {cur.exp_sync[0], ext_expansion};

      // read data and error captured in setup so the access answers at once
      if (apb_setup)
      begin
         next_cur.pslverr = !(psc_hit || stat_hit);
         if (psc_hit)
            next_cur.prdata = {24'h00_0000, cur.power_save_ctrl_reg};
         else if (stat_hit)
            next_cur.prdata = stat_word;
         else
            next_cur.prdata = SMC_PRDATA_RESET;
      end

      // control register write, reserved bits 3 and 0 stay zero
      if (apb_wr && psc_hit && cur.mode == SMC_RUN)
      begin
         next_cur.power_save_ctrl_reg[SMC_DIS_HI_BIT] = wr_byte[SMC_DIS_HI_BIT];
         next_cur.power_save_ctrl_reg[SMC_DIS_LO_BIT] = wr_byte[SMC_DIS_LO_BIT];
         next_cur.power_save_ctrl_reg[SMC_STAB_CLOCK_SELECT_BIT] = wr_byte[SMC_STAB_CLOCK_SELECT_BIT];
         next_cur.power_save_ctrl_reg[SMC_OSC_SOURCE_SELECT_BIT] = wr_byte[SMC_OSC_SOURCE_SELECT_BIT];
         next_cur.power_save_ctrl_reg[SMC_IDLE_BIT] = wr_byte[SMC_IDLE_BIT];
         next_cur.power_save_ctrl_reg[SMC_STP_BIT] = wr_byte[SMC_STP_BIT];
         // stop bit alone does nothing; idle bit starts either mode
         if (wr_byte[SMC_IDLE_BIT])
         begin
            next_cur.in_nmi = nmi_in_service;
            if (wr_byte[SMC_STP_BIT])
               next_cur.mode = SMC_STOP;
            else
               next_cur.mode = SMC_IDLE;
         end
      end

      // mode sequencing; only the nmi pin or the reset pin wake the block
      case (cur.mode)
         SMC_RUN:
         begin
            // nothing to release
         end
         SMC_IDLE:
         begin
            if (nmi_valid_edge)
            begin
               // no stabilisation wait, clock resumes next cycle
               next_cur.mode = SMC_RUN;
               next_cur.power_save_ctrl_reg[SMC_IDLE_BIT] = 1'b0;
               next_cur.power_save_ctrl_reg[SMC_STP_BIT] = 1'b0;
               next_cur.ack = !cur.in_nmi;
               next_cur.pend = cur.in_nmi;
            end
         end
         SMC_STOP:
         begin
            // the edge releases stop; counting waits for the inactive edge
            if (nmi_valid_edge)
               next_cur.mode = SMC_WAIT_INACT;
         end
         SMC_WAIT_INACT:
         begin
            // relies on the source returning to inactive level
            if (nmi_inactive)
            begin
               if (skip_count)
               begin
                  next_cur.mode = SMC_RUN;
                  next_cur.power_save_ctrl_reg[SMC_IDLE_BIT] = 1'b0;
                  next_cur.power_save_ctrl_reg[SMC_STP_BIT] = 1'b0;
                  next_cur.ack = !cur.in_nmi;
                  next_cur.pend = cur.in_nmi;
               end
               else
               begin
                  next_cur.mode = SMC_STAB;
                  next_cur.tbc_start = 1'b1;
               end
            end
         end
         SMC_STAB:
         begin
            // execution held until the count ends
            if (tbc_done)
            begin
               next_cur.mode = SMC_RUN;
               next_cur.power_save_ctrl_reg[SMC_IDLE_BIT] = 1'b0;
               next_cur.power_save_ctrl_reg[SMC_STP_BIT] = 1'b0;
               next_cur.ack = !cur.in_nmi;
               next_cur.pend = cur.in_nmi;
            end
         end
         default:
         begin
            next_cur.mode = SMC_RUN;
         end
      endcase

      // reset pin: same as system reset, from any mode, over everything else
      if (rst_active)
      begin
         next_cur.mode = SMC_RUN;
         next_cur.power_save_ctrl_reg = SMC_PSC_RESET;
         next_cur.in_nmi = 1'b0;
         next_cur.ack = 1'b0;
         next_cur.pend = 1'b0;
         next_cur.tbc_start = 1'b0;
      end
   end

   // single state register; synchronisers reset to the pins' idle levels
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur <= '0;
         cur.mode <= SMC_RUN;
         cur.power_save_ctrl_reg <= SMC_PSC_RESET;
         cur.prdata <= SMC_PRDATA_RESET;
         cur.nmi_sync <= NMI_VALID_FALLING ? 3'h7 : 3'h0;
         cur.rst_sync <= 2'h3;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // apb answer: zero wait states, data already captured
   assign prdata = cur.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && cur.pslverr;

   // system clock gated in every standby mode and while reset is low;
   // gating the clock is what halts cpu and peripherals with contents held
   assign sys_clock_en = !standby && !rst_active;

   // oscillator and pll stop from stop entry until the nmi edge;
   // while reset is low they run so the level width covers stabilisation
   assign osc_enable = (cur.mode != SMC_STOP) || rst_active;
   assign pll_enable = (cur.mode != SMC_STOP) || rst_active;
   assign osc_feedback_cut = cur.mode == SMC_STOP && cur.power_save_ctrl_reg[SMC_OSC_SOURCE_SELECT_BIT];

   // external bus pins; strobes forced high in standby with expansion, refresh never stops
   assign bus_drive_en = !(standby && cur.exp_sync[1]);
   assign strobes_force_high = standby && cur.exp_sync[1];
   assign dram_refresh_run = 1'b1;

   // hold and wait ignored, acknowledge floated in standby
   assign bus_hold_ack_oe = !standby;
   assign hold_wait_sample_en = !standby;

   // sys_clock_out_pin held low in standby unless inhibited or in flash programming
   assign sys_clock_out_pin_run = !standby;
   assign sys_clock_out_pin_oe = !cur.flash_sync[1] &&
      ({cur.power_save_ctrl_reg[SMC_DIS_HI_BIT], cur.power_save_ctrl_reg[SMC_DIS_LO_BIT]} != SMC_SYS_CLOCK_OUT_PIN_INHIBIT);

   // nmi outcome pulses and reset request
   assign nmi_wake_ack = cur.ack;
   assign nmi_wake_pend = cur.pend;
   assign sys_reset_req = rst_active;

endmodule : smc_ctrl

// ---- shared/smc_pkg.sv ----
// constants shared by the standby mode controller and its time base counter
// assumes a 32-bit apb master and a resonator-derived pclk
package smc_pkg;

   // register byte offsets
   localparam logic [11:0] SMC_PSC_OFFSET = 12'h000; // power_save_ctrl_reg
   localparam logic [11:0] SMC_STAT_OFFSET = 12'h004; // standby status word

   // power_save_ctrl_reg field positions
   localparam int SMC_DIS_HI_BIT = 7; // sys_clock_out_pin_disable_hi
   localparam int SMC_DIS_LO_BIT = 6; // sys_clock_out_pin_disable_lo
   localparam int SMC_STAB_CLOCK_SELECT_BIT = 5; // stab_clock_select
   localparam int SMC_OSC_SOURCE_SELECT_BIT = 4; // osc_source_select
   localparam int SMC_IDLE_BIT = 2; // idle request
   localparam int SMC_STP_BIT = 1; // stop_request_bit

   // status word field positions
   localparam int SMC_ST_IDLE_BIT = 0; // in idle
   localparam int SMC_ST_STOP_BIT = 1; // in software stop
   localparam int SMC_ST_INACT_BIT = 2; // waiting for nmi inactive edge
   localparam int SMC_ST_STAB_BIT = 3; // stabilisation count running
   localparam int SMC_ST_RST_BIT = 4; // reset pin held low
   localparam int SMC_ST_STRAP_BIT = 5; // direct_clock_strap level

   // reset values and the sys_clock_out_pin inhibit code
   localparam logic [7:0] SMC_PSC_RESET = 8'h00;
   localparam logic [31:0] SMC_PRDATA_RESET = 32'h0000_0000;
   localparam logic [1:0] SMC_SYS_CLOCK_OUT_PIN_INHIBIT = 2'h3; // both disable bits set

   // time base counter: resonator cycles per tick is 2^(8 + select)
   localparam int SMC_TBC_DIV_LOG2 = 8;
   localparam int SMC_TBC_TICKS = 256; // ticks to terminal count

   // controller modes
   typedef enum logic [2:0] {
      SMC_RUN,
      SMC_IDLE,
      SMC_STOP,
      SMC_WAIT_INACT,
      SMC_STAB
   } smc_mode_t;

endpackage : smc_pkg

// ---- src/smc_tbc.sv ----
// time base counter timing oscillator stabilisation after stop release
// assumes clk is the resonator clock and start is a one-cycle pulse
`timescale 1ns/1ps
module smc_tbc #(
   parameter int DIV_LOG2 = smc_pkg::SMC_TBC_DIV_LOG2,
   parameter int TICKS = smc_pkg::SMC_TBC_TICKS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic sel,
   output logic busy,
   output logic done
);
   import smc_pkg::*;

   localparam int PW = DIV_LOG2 + 2; // prescaler width, covers 2^(div+1)
   localparam int TW = $clog2(TICKS) + 1; // tick counter width
   localparam logic [TW-1:0] TICK_LAST = TW'(TICKS - 1);

   typedef struct packed {
      logic busy; // counting in progress
      logic done; // terminal count pulse
      logic sel; // select caught at start
      logic [PW-1:0] pre; // resonator cycle prescaler
      logic [TW-1:0] ticks; // divided clock ticks
   } smc_tbc_t;

   smc_tbc_t cur;
   smc_tbc_t next_cur;
   logic [PW-1:0] pre_last; // last prescaler value for the chosen ratio

   // prescaler wraps at 2^8 or 2^9 resonator cycles
   always_comb
   begin
      pre_last = cur.sel ? PW'((1 << (DIV_LOG2 + 1)) - 1) : PW'((1 << DIV_LOG2) - 1);
      next_cur = cur;
      next_cur.done = 1'b0;
      if (start)
      begin
         // restart from zero, select sampled once so a later write cannot skew it
         next_cur.busy = 1'b1;
         next_cur.sel = sel;
         next_cur.pre = '0;
         next_cur.ticks = '0;
      end
      else if (cur.busy)
      begin
         if (cur.pre == pre_last)
         begin
            next_cur.pre = '0;
            if (cur.ticks == TICK_LAST)
            begin
               // terminal count: about 2^16 or 2^17 resonator cycles
               next_cur.busy = 1'b0;
               next_cur.done = 1'b1;
            end
            else
            begin
               next_cur.ticks = cur.ticks + TW'(1);
            end
         end
         else
         begin
            next_cur.pre = cur.pre + PW'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cur <= '0;
      else
         cur <= next_cur;
   end

   assign busy = cur.busy;
   assign done = cur.done;

endmodule : smc_tbc

// ---- tb/smc_ctrl_assertions.sv ----
// port checker for the standby mode controller
// assumes it is bound into smc_ctrl and sees only its ports
`timescale 1ns/1ps
module smc_ctrl_assertions
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic nmi_pin,
   input wire logic reset_pin_n,
   input wire logic flash_prog_mode,
   input wire logic sys_clock_en,
   input wire logic osc_enable,
   input wire logic pll_enable,
   input wire logic bus_drive_en,
   input wire logic strobes_force_high,
   input wire logic dram_refresh_run,
   input wire logic bus_hold_ack_oe,
   input wire logic hold_wait_sample_en,
   input wire logic sys_clock_out_pin_run,
   input wire logic sys_clock_out_pin_oe,
   input wire logic nmi_wake_ack,
   input wire logic nmi_wake_pend,
   input wire logic sys_reset_req
);
   // single clock domain
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // accepted control write while running
   logic wr_psc;
   assign wr_psc = psel && penable && pwrite && paddr == SMC_PSC_OFFSET
      && sys_clock_en && !sys_reset_req;
   property p_idle_in;
      wr_psc && pwdata[2] && !pwdata[1] |=> !sys_clock_en && osc_enable && pll_enable;
   endproperty
   a_idle_in: assert property (p_idle_in) else $error("idle entry wrong");
   property p_stop_in;
      wr_psc && pwdata[2] && pwdata[1] |=> !osc_enable && !pll_enable && !sys_clock_en;
   endproperty
   a_stop_in: assert property (p_stop_in) else $error("stop entry wrong");
   // hold/wait ignored and clock pin low for a while after entry
   property p_hold;
      wr_psc && pwdata[2] |=> (!bus_hold_ack_oe && !hold_wait_sample_en && !sys_clock_out_pin_run)[*3];
   endproperty
   a_hold: assert property (p_hold) else $error("standby pins wrong");
   property p_float;
      !bus_drive_en |-> strobes_force_high && dram_refresh_run;
   endproperty
   a_float: assert property (p_float) else $error("bus float wrong");
   // flash level must cross the synchroniser first
   property p_flash;
      flash_prog_mode [*4] |-> !sys_clock_out_pin_oe;
   endproperty
   a_flash: assert property (p_flash) else $error("sys_clock_out_pin in flash");
   property p_inhibit;
      wr_psc && pwdata[7:6] == SMC_SYS_CLOCK_OUT_PIN_INHIBIT |=> !sys_clock_out_pin_oe;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("sys_clock_out_pin not inhibited");
   property p_wake;
      nmi_wake_ack || nmi_wake_pend |-> sys_clock_en && !(nmi_wake_ack && nmi_wake_pend);
   endproperty
   a_wake: assert property (p_wake) else $error("wake pulse wrong");
   property p_rst_pin;
      !reset_pin_n [*3] |-> sys_reset_req && !sys_clock_en;
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin ignored");
   // active nmi level keeps the count from starting
   property p_nmi_hold;
      (!nmi_pin && !sys_clock_en && !sys_reset_req)[*5] |=> !sys_clock_en;
   endproperty
   a_nmi_hold: assert property (p_nmi_hold) else $error("woke before inactive edge");
   c_ack: cover property (nmi_wake_ack);
   c_pend: cover property (nmi_wake_pend);
   c_stop: cover property (!osc_enable);
endmodule : smc_ctrl_assertions

bind smc_ctrl smc_ctrl_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .nmi_pin, .reset_pin_n, .flash_prog_mode, .sys_clock_en,
   .osc_enable, .pll_enable, .bus_drive_en, .strobes_force_high, .dram_refresh_run,
   .bus_hold_ack_oe, .hold_wait_sample_en, .sys_clock_out_pin_run, .sys_clock_out_pin_oe, .nmi_wake_ack,
   .nmi_wake_pend, .sys_reset_req);

// ---- tb/smc_pin_src.sv ----
// model of the external nmi and reset pin sources
// assumes the bench calls its tasks; pins idle high
`timescale 1ns/1ps
module smc_pin_src (
   input wire logic clk,
   output logic nmi_pin,
   output logic reset_pin_n
);
   // both pins rest inactive
   initial
   begin
      nmi_pin = 1'b1;
      reset_pin_n = 1'b1;
   end
   // falling valid edge, active for n cycles, then inactive edge
   task automatic nmi_low(input int n);
      @(posedge clk);
      nmi_pin <= 1'b0;
      repeat (n) @(posedge clk);
      nmi_pin <= 1'b1;
   endtask : nmi_low
   // low width must cover oscillator settling
   task automatic reset_low(input int n);
      @(posedge clk);
      reset_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      reset_pin_n <= 1'b1;
   endtask : reset_low
endmodule : smc_pin_src

// ---- tb/smc_ctrl_tb.sv ----
// self-checking bench for the standby mode controller
// assumes a shortened time base counter and the pin source model
`timescale 1ns/1ps
module smc_ctrl_tb;
   import smc_pkg::*;
   localparam int DIV = 2; // shortened divider log2
   localparam int TICKS = 4; // shortened terminal count
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic nmi_pin, reset_pin_n, direct_clock_strap, flash_prog_mode;
   logic ext_expansion, nmi_in_service, sys_clock_en, osc_enable, pll_enable;
   logic osc_feedback_cut, bus_drive_en, strobes_force_high, dram_refresh_run;
   logic bus_hold_ack_oe, hold_wait_sample_en, sys_clock_out_pin_run, sys_clock_out_pin_oe;
   logic nmi_wake_ack, nmi_wake_pend, sys_reset_req;
   int n_mismatch, check_count;
   smc_ctrl #(.TBC_DIV_LOG2(DIV), .TBC_TICKS(TICKS), .NMI_VALID_FALLING(1'b1)) uut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .nmi_pin, .reset_pin_n, .direct_clock_strap, .flash_prog_mode,
      .ext_expansion, .nmi_in_service, .sys_clock_en, .osc_enable, .pll_enable,
      .osc_feedback_cut, .bus_drive_en, .strobes_force_high, .dram_refresh_run,
      .bus_hold_ack_oe, .hold_wait_sample_en, .sys_clock_out_pin_run, .sys_clock_out_pin_oe,
      .nmi_wake_ack, .nmi_wake_pend, .sys_reset_req);
   smc_pin_src src (.clk(pclk), .nmi_pin(nmi_pin), .reset_pin_n(reset_pin_n));
   // 25 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // one apb transfer; read data and error land in rd and err
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 16)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // bounded wait for the system clock; pulses seen in that cycle
   task automatic wait_en(input int lim, output int n, output logic a, output logic p);
      for (n = 0; n < lim; n++)
      begin
         @(negedge pclk);
         if (sys_clock_en === 1'b1)
            break;
      end
      a = nmi_wake_ack;
      p = nmi_wake_pend;
      if (n == lim)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : wait_en
   task automatic t_regs();
      apb(1'b0, SMC_PSC_OFFSET, 32'h0);
      chk("psc reset", {24'h0, SMC_PSC_RESET}, rd);
      apb(1'b1, SMC_PSC_OFFSET, 32'h40);
      apb(1'b0, SMC_PSC_OFFSET, 32'h0);
      chk("psc readback", 32'h40, rd);
      chk("sys_clock_out_pin reserved", 1, sys_clock_out_pin_oe);
      apb(1'b1, SMC_PSC_OFFSET, 32'hC0);
      @(negedge pclk);
      chk("sys_clock_out_pin inhibit", 0, sys_clock_out_pin_oe);
      apb(1'b1, SMC_PSC_OFFSET, 32'h0);
      flash_prog_mode <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("sys_clock_out_pin flash", 0, sys_clock_out_pin_oe);
      flash_prog_mode <= 1'b0;
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      $display("done t_regs");
   endtask : t_regs
   task automatic t_idle(input logic s);
      int n;
      logic a, p;
      nmi_in_service <= s;
      apb(1'b1, SMC_PSC_OFFSET, 32'h4);
      repeat (8) @(negedge pclk);
      chk("idle clk", 0, sys_clock_en);
      chk("idle osc", 1, osc_enable & pll_enable);
      chk("idle float", 0, bus_drive_en);
      chk("idle strobes", 1, strobes_force_high);
      chk("idle sys_clock_out_pin", 0, sys_clock_out_pin_run);
      chk("idle hold", 0, bus_hold_ack_oe | hold_wait_sample_en);
      chk("idle dram", 1, dram_refresh_run);
      apb(1'b0, SMC_STAT_OFFSET, 32'h0);
      chk("idle status", 32'h1, rd);
      fork
         src.nmi_low(3);
         wait_en(12, n, a, p);
      join
      chk("idle fast exit", 1, n <= 6);
      chk("idle ack", !s, a);
      chk("idle pend", s, p);
      apb(1'b0, SMC_PSC_OFFSET, 32'h0);
      chk("idle bit clear", 0, rd[2:1]);
      $display("done t_idle");
   endtask : t_idle
   task automatic t_stop(input logic sel, input logic ces, input logic s);
      int n, lo;
      logic a, p;
      lo = ces ? 0 : TICKS << (DIV + sel);
      nmi_in_service <= s;
      apb(1'b1, SMC_PSC_OFFSET, {26'h0, sel, ces, 4'h6});
      @(negedge pclk);
      chk("stop clocks", 0, osc_enable | pll_enable | sys_clock_en);
      chk("stop fb cut", ces, osc_feedback_cut);
      apb(1'b0, SMC_STAT_OFFSET, 32'h0);
      chk("stop status", 32'h2, rd);
      fork
         src.nmi_low(10);
         begin
            repeat (8) @(negedge pclk);
            chk("wait inactive", 0, sys_clock_en);
         end
      join
      wait_en(80, n, a, p);
      chk("stab time", 1, n >= lo && n <= lo + 6);
      chk("stop ack", !s, a);
      chk("stop pend", s, p);
      apb(1'b0, SMC_PSC_OFFSET, 32'h0);
      chk("stop bits clear", 0, rd[2:1]);
      $display("done t_stop");
   endtask : t_stop
   task automatic t_rst_pin();
      int n;
      logic a, p;
      nmi_in_service <= 1'b0;
      apb(1'b1, SMC_PSC_OFFSET, 32'h6);
      repeat (4) @(posedge pclk);
      fork
         src.reset_low(8);
         begin
            repeat (6) @(negedge pclk);
            chk("reset req", 1, sys_reset_req);
            chk("reset clk", 0, sys_clock_en);
         end
      join
      wait_en(8, n, a, p);
      apb(1'b0, SMC_PSC_OFFSET, 32'h0);
      chk("psc after pin", 0, rd);
      $display("done t_rst_pin");
   endtask : t_rst_pin
   // main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      direct_clock_strap = 1'b0;
      flash_prog_mode = 1'b0;
      ext_expansion = 1'b1;
      nmi_in_service = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      t_regs();
      t_idle(1'b0);
      t_idle(1'b1);
      t_stop(1'b0, 1'b0, 1'b0);
      t_stop(1'b1, 1'b0, 1'b1);
      t_stop(1'b0, 1'b1, 1'b0);
      t_rst_pin();
      tally_and_finish();
   end
endmodule : smc_ctrl_tb
